// ---- hw/pwr_ctl_pkg.sv ----
// constants and state encoding for the module power and reset controller
package pwr_ctl_pkg;
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    // emergency-off hold time on the hard reset line, in seconds
    localparam int unsigned EMERG_OFF_S = 8;
    localparam longint unsigned EMERG_OFF_CYCLES_L = longint'(EMERG_OFF_S) * longint'(CLK_FREQ_HZ);
    localparam int unsigned EMERG_OFF_CYCLES = int'(EMERG_OFF_CYCLES_L);
    // power request recognised after this low time, in ms
    localparam int unsigned PWR_REQ_MS = 200;
    localparam longint unsigned PWR_REQ_CYCLES_L = longint'(PWR_REQ_MS) * longint'(CLK_FREQ_HZ) / 64'd1000;
    localparam int unsigned PWR_REQ_CYCLES = int'(PWR_REQ_CYCLES_L);
    // reset and restart pulse driven to the core lasts at least this many cycles plus one
    localparam int unsigned RESET_PULSE_CYCLES = 16;
    localparam int unsigned CNT_W = 32;

    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_ON      = 3'b001,
        ST_RESET   = 3'b011,
        ST_RESTART = 3'b010,
        ST_EMERG   = 3'b110
    } pwr_state_e;
endpackage : pwr_ctl_pkg

// ---- hw/low_timer.sv ----
// saturating timer that counts how long a level has been held
`timescale 1ns/10ps
module low_timer #(
    parameter int unsigned LIMIT = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic level_in,
    output logic reached
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    wire logic at_limit = (cnt_r >= LIMIT[31:0]);

    assign cnt_nxt = !level_in ? 32'h0000_0000 : (at_limit ? cnt_r : cnt_r + 32'h0000_0001);
    assign reached = at_limit;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 32'h0000_0000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule : low_timer

// ---- hw/pwr_ctl.sv ----
// power, reset and shutdown sequencing logic of the cellular module
// Behaviour
// - reset held 8 s, request released: power off
// - request held low 200 ms with supply present turns on
// - reset while request held: core reset
// - short reset pulse, request released: reset
// - shutdown command, request held: restart
// - shutdown command, request released: stay off
`timescale 1ns/10ps
module pwr_ctl
    import pwr_ctl_pkg::*;
#(
    parameter int unsigned EMERG_CYCLES = EMERG_OFF_CYCLES,
    parameter int unsigned REQ_CYCLES = PWR_REQ_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic POWER_REQ_N,
    input wire logic HARD_RESET_N,
    input wire logic MAIN_BATTERY_SUPPLY,
    input wire logic SHUTDOWN_COMMAND,
    output logic CORE_POWER_EN,
    output logic CORE_RESET_N,
    output logic [2:0] PWR_STATE
);
    // ==========================================================
    // input synchronisers
    // ==========================================================
    logic req_meta_r;
    logic req_sync_r;
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_prev_r;

    // both lines become active-high levels here, so nothing downstream deals with polarity
    wire logic req_meta_nxt = !POWER_REQ_N;
    wire logic rst_meta_nxt = !HARD_RESET_N;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            req_meta_r <= 1'b0;
        end else begin
            req_meta_r <= req_meta_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            req_sync_r <= 1'b0;
        end else begin
            req_sync_r <= req_meta_r;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rst_meta_r <= 1'b0;
        end else begin
            rst_meta_r <= rst_meta_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rst_sync_r <= 1'b0;
        end else begin
            rst_sync_r <= rst_meta_r;
        end
    end

    // resets to the idle level, so no false release is seen right after reset
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rst_prev_r <= 1'b0;
        end else begin
            rst_prev_r <= rst_sync_r;
        end
    end

    // ==========================================================
    // hold timers
    // ==========================================================
    wire logic req_valid;
    wire logic emerg_hit;

    // counting only while the request is released keeps a held request from ever causing emergency off
    wire logic emerg_level = rst_sync_r && !req_sync_r;

    // a short glitch on the request line must not start the core
    low_timer #(.LIMIT(REQ_CYCLES)) u_req_timer (
        .clk(SYS_CLK),
        .rst(RST),
        .level_in(req_sync_r),
        .reached(req_valid)
    );

    // the emergency path only fires once the full hold time has been counted
    low_timer #(.LIMIT(EMERG_CYCLES)) u_emerg_timer (
        .clk(SYS_CLK),
        .rst(RST),
        .level_in(emerg_level),
        .reached(emerg_hit)
    );

    // ==========================================================
    // transition conditions
    // ==========================================================
    pwr_state_e state_r;
    pwr_state_e state_nxt;
    logic [4:0] pulse_r;
    logic [4:0] pulse_nxt;

    wire logic power_up = req_valid && MAIN_BATTERY_SUPPLY;
    wire logic supply_lost = !MAIN_BATTERY_SUPPLY;
    wire logic reset_held = rst_sync_r && req_sync_r;
    wire logic rst_release = rst_prev_r && !rst_sync_r;
    // with the request still held a shutdown becomes a restart, otherwise the core stays off
    wire logic restart_wanted = SHUTDOWN_COMMAND && req_sync_r;
    wire logic off_wanted = SHUTDOWN_COMMAND && !req_sync_r;
    wire logic pulse_done = (pulse_r == 5'(RESET_PULSE_CYCLES));
    wire logic [4:0] pulse_inc = pulse_done ? pulse_r : pulse_r + 5'h01;
    // a reset or restart ends only after the full pulse and once the reset line is let go
    wire logic pulse_exit = pulse_done && !rst_sync_r;

    // ==========================================================
    // state sequencing
    // ==========================================================
    always_comb begin
        state_nxt = state_r;
        pulse_nxt = 5'h00;
        case (state_r)
            ST_OFF: begin
                // supply first or request first both end here once both stand
                if (power_up) begin
                    state_nxt = ST_ON;
                end
            end
            ST_ON: begin
                if (supply_lost) begin
                    state_nxt = ST_OFF;
                end else if (emerg_hit) begin
                    state_nxt = ST_EMERG;
                end else if (reset_held) begin
                    state_nxt = ST_RESET;
                end else if (rst_release) begin
                    state_nxt = ST_RESET;
                end else if (restart_wanted) begin
                    state_nxt = ST_RESTART;
                end else if (off_wanted) begin
                    state_nxt = ST_OFF;
                end
            end
            ST_RESET, ST_RESTART: begin
                pulse_nxt = pulse_inc;
                if (supply_lost) begin
                    state_nxt = ST_OFF;
                end else if (emerg_hit) begin
                    state_nxt = ST_EMERG;
                end else if (pulse_exit) begin
                    state_nxt = ST_ON;
                end
            end
            ST_EMERG: begin
                // stay down until the reset line is released, then wait for a fresh request
                if (!rst_sync_r) begin
                    state_nxt = ST_OFF;
                end
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
    end

    // ==========================================================
    // state and output registers
    // ==========================================================
    // core supply stays up through a plain reset but drops for a restart or an emergency off
    wire logic power_en_nxt = (state_nxt == ST_ON) || (state_nxt == ST_RESET);
    wire logic core_rst_n_nxt = (state_nxt == ST_ON);
    wire logic [2:0] state_code_nxt = state_nxt;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            pulse_r <= 5'h00;
        end else begin
            pulse_r <= pulse_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CORE_POWER_EN <= 1'b0;
        end else begin
            CORE_POWER_EN <= power_en_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CORE_RESET_N <= 1'b0;
        end else begin
            CORE_RESET_N <= core_rst_n_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PWR_STATE <= 3'h0;
        end else begin
            PWR_STATE <= state_code_nxt;
        end
    end
endmodule : pwr_ctl

// ---- bench/pwr_ctl_asserts.sv ----
// assertion checker for the power and reset controller
`timescale 1ns/10ps
module pwr_ctl_asserts
    import pwr_ctl_pkg::*;
#(
    parameter int unsigned EMERG_CYCLES = EMERG_OFF_CYCLES,
    parameter int unsigned REQ_CYCLES = PWR_REQ_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic POWER_REQ_N,
    input wire logic HARD_RESET_N,
    input wire logic MAIN_BATTERY_SUPPLY,
    input wire logic SHUTDOWN_COMMAND,
    input wire logic CORE_POWER_EN,
    input wire logic CORE_RESET_N,
    input wire logic [2:0] PWR_STATE
);
    // ==========
    // raw low time; the two-flop sync lag is covered by margins below
    logic [31:0] low_cnt_r;
    always_ff @(posedge SYS_CLK) begin
        low_cnt_r <= (RST || HARD_RESET_N) ? 32'h0000_0000 : low_cnt_r + 32'h0000_0001;
    end
    // raw request low time; read three cycles back to line up with the synchronised timer
    logic [31:0] req_cnt_r;
    always_ff @(posedge SYS_CLK) begin
        req_cnt_r <= (RST || POWER_REQ_N) ? 32'h0000_0000 : req_cnt_r + 32'h0000_0001;
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    property p_dark; (PWR_STATE inside {ST_OFF, ST_RESTART, ST_EMERG})[*2] |-> !CORE_POWER_EN; endproperty
    a_dark: assert property (p_dark) else $error("core power on");
    property p_hold; (PWR_STATE != ST_ON)[*2] |-> !CORE_RESET_N; endproperty
    a_hold: assert property (p_hold) else $error("core out of reset");
    property p_rst; (!POWER_REQ_N && !HARD_RESET_N && PWR_STATE == ST_ON)[*3] |-> ##[0:2] PWR_STATE == ST_RESET; endproperty
    a_rst: assert property (p_rst) else $error("no reset");
    property p_rs; (!POWER_REQ_N && HARD_RESET_N)[*3] ##0 (SHUTDOWN_COMMAND && PWR_STATE == ST_ON)
        |-> ##[1:4] PWR_STATE == ST_RESTART; endproperty
    a_rs: assert property (p_rs) else $error("no restart");
    property p_off; (POWER_REQ_N && HARD_RESET_N)[*3] ##0 (SHUTDOWN_COMMAND && PWR_STATE == ST_ON)
        |-> ##[1:4] PWR_STATE == ST_OFF; endproperty
    a_off: assert property (p_off) else $error("no switch off");
    property p_back; PWR_STATE == ST_RESTART |-> ##[1:40] PWR_STATE == ST_ON; endproperty
    a_back: assert property (p_back) else $error("restart stuck");
    property p_em; !HARD_RESET_N && PWR_STATE == ST_EMERG |-> low_cnt_r >= EMERG_CYCLES; endproperty
    a_em: assert property (p_em) else $error("early emergency off");
    property p_sh; $rose(HARD_RESET_N) && POWER_REQ_N && PWR_STATE == ST_ON && low_cnt_r inside {[4:50]}
        |-> ##[1:4] PWR_STATE == ST_RESET; endproperty
    a_sh: assert property (p_sh) else $error("short pulse no reset");
    property p_up; PWR_STATE == ST_ON && $past(PWR_STATE) == ST_OFF
        |-> $past(req_cnt_r, 3) >= REQ_CYCLES && $past(MAIN_BATTERY_SUPPLY); endproperty
    a_up: assert property (p_up) else $error("power up without held request");
    c_em: cover property (PWR_STATE == ST_EMERG);
    c_rs: cover property (PWR_STATE == ST_RESTART);
    c_rst: cover property (PWR_STATE == ST_RESET);
endmodule : pwr_ctl_asserts
bind pwr_ctl pwr_ctl_asserts #(
    .EMERG_CYCLES(EMERG_CYCLES),
    .REQ_CYCLES(REQ_CYCLES)
) chk_i (
    .SYS_CLK(SYS_CLK),
    .RST(RST),
    .POWER_REQ_N(POWER_REQ_N),
    .HARD_RESET_N(HARD_RESET_N),
    .MAIN_BATTERY_SUPPLY(MAIN_BATTERY_SUPPLY),
    .SHUTDOWN_COMMAND(SHUTDOWN_COMMAND),
    .CORE_POWER_EN(CORE_POWER_EN),
    .CORE_RESET_N(CORE_RESET_N),
    .PWR_STATE(PWR_STATE)
);

// ---- bench/host_model.sv ----
// host model driving the request, hard reset and shutdown lines
`timescale 1ns/10ps
module host_model (
    input wire logic clk,
    output logic req_n,
    output logic hrst_n,
    output logic cmd
);
    // ==========
    // lines idle while the device comes up
    initial {req_n, hrst_n, cmd} = 3'h6;
    // callers release req_n before a long hrst_n pulse
    task automatic drive(input logic r, input logic h, input logic c, input int n);
        req_n <= r;
        hrst_n <= h;
        cmd <= c;
        repeat (n) @(posedge clk);
    endtask : drive
endmodule : host_model

// ---- bench/tb_module_power_reset_control.sv ----
// self-checking bench for the power and reset controller
`timescale 1ns/10ps
module tb_module_power_reset_control import pwr_ctl_pkg::*; ;
    logic SYS_CLK = 1'h0, RST = 1'h1, supply = 1'h0, req_n, hrst_n, cmd;
    logic [2:0] state, last_st = 3'h0;
    logic [2:0] exp_st;
    logic pwr_en, core_rst_n;
    pwr_state_e exp_q[$];
    int n_fail = 0, num_checks = 0, seed = 32'h4763_0eae, k;
    always #5 SYS_CLK = ~SYS_CLK;
    host_model host (.clk(SYS_CLK), .req_n(req_n), .hrst_n(hrst_n), .cmd(cmd));
    pwr_ctl #(.EMERG_CYCLES(100), .REQ_CYCLES(10)) uut (.SYS_CLK(SYS_CLK), .RST(RST), .POWER_REQ_N(req_n),
        .HARD_RESET_N(hrst_n), .MAIN_BATTERY_SUPPLY(supply), .SHUTDOWN_COMMAND(cmd),
        .CORE_POWER_EN(pwr_en), .CORE_RESET_N(core_rst_n), .PWR_STATE(state));
    task automatic chk(input logic [2:0] exp, input logic [2:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    // expected {power enable, reset release} for a state
    function automatic logic [1:0] pins_of(input logic [2:0] s);
        case (s)
            ST_ON: pins_of = 2'h3;
            ST_RESET: pins_of = 2'h2;
            default: pins_of = 2'h0;
        endcase
    endfunction : pins_of
    task automatic chk_pins(input logic [1:0] exp, input logic [1:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t pins exp=%h got=%h", $time, exp, got);
        end
    endtask : chk_pins
    task automatic tally_and_finish();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // ==========
    // every state change must match the oldest note
    always @(posedge SYS_CLK) begin
        if (!RST && state !== last_st) begin
            last_st = state;
            exp_st = exp_q.size() ? exp_q.pop_front() : 3'h7;
            chk(exp_st, state);
            chk_pins(pins_of(exp_st), {pwr_en, core_rst_n});
        end
    end
    initial begin
        repeat (3000) @(posedge SYS_CLK);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge SYS_CLK);
        RST <= 1'h0;
        k = 12 + ($unsigned($random(seed)) % 8);
        exp_q.push_back(ST_ON);
        host.drive(1'h0, 1'h1, 1'h0, 30);
        supply <= 1'h1;
        host.drive(1'h0, 1'h1, 1'h0, 10);
        exp_q.push_back(ST_RESET);
        exp_q.push_back(ST_ON);
        host.drive(1'h0, 1'h0, 1'h0, k);
        host.drive(1'h0, 1'h1, 1'h0, 40);
        exp_q.push_back(ST_RESTART);
        exp_q.push_back(ST_ON);
        host.drive(1'h0, 1'h1, 1'h1, 1);
        host.drive(1'h0, 1'h1, 1'h0, 60);
        exp_q.push_back(ST_RESET);
        exp_q.push_back(ST_ON);
        host.drive(1'h1, 1'h1, 1'h0, 5);
        host.drive(1'h1, 1'h0, 1'h0, k + 20);
        host.drive(1'h1, 1'h1, 1'h0, 40);
        exp_q.push_back(ST_EMERG);
        exp_q.push_back(ST_OFF);
        host.drive(1'h1, 1'h0, 1'h0, 130);
        host.drive(1'h1, 1'h1, 1'h0, 10);
        exp_q.push_back(ST_ON);
        host.drive(1'h0, 1'h1, 1'h0, 30);
        exp_q.push_back(ST_OFF);
        host.drive(1'h1, 1'h1, 1'h0, 5);
        host.drive(1'h1, 1'h1, 1'h1, 1);
        host.drive(1'h1, 1'h1, 1'h0, 10);
        // supply loss takes a running core straight down
        exp_q.push_back(ST_ON);
        exp_q.push_back(ST_OFF);
        host.drive(1'h0, 1'h1, 1'h0, 30);
        supply <= 1'h0;
        host.drive(1'h0, 1'h1, 1'h0, 10);
        chk(3'h0, 3'(exp_q.size()));
        tally_and_finish();
    end
endmodule : tb_module_power_reset_control
